/* File: testbench/seep_master_model.sv */
`timescale 1ns/1ns

// Behavioural two-wire bus master that makes SCL and drives SDA open drain.
module seep_master_model (
  // System clock that paces every bus phase.
  input wire logic clk,
  // Resolved level of the SDA wire.
  input wire logic sdaWire,
  // Bus clock and data drive; a high drive means released.
  output logic scl,
  output logic sdaDrv
);
  // Both lines rest high, so SCL stands still between frames.
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Lets a number of system clock edges pass.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // SDA falls while SCL is high; the extra wait lets a slave acknowledge end first.
  task automatic start_cond();
    sdaDrv <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(2);
    sdaDrv <= 1'b0;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask

  // SDA rises while SCL is high.
  task automatic stop_cond();
    sdaDrv <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(2);
    sdaDrv <= 1'b1;
    tick(4);
  endtask

  // One bit: data set while SCL is low and held over the high phase.
  // Each bit takes a fixed eight system clocks, so SCL never runs faster than that.
  task automatic bit_xfer(input logic b, output logic r);
    sdaDrv <= b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    r = sdaWire;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask

  // Sends a byte MSB first and releases SDA for the acknowledge slot.
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, r);
    ack = (r === 1'b0);
  endtask

  // Reads a byte and acknowledges it only when more is wanted.
  task automatic byte_r(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(~more, r);
  endtask
endmodule

/* File: testbench/seep_slave_bench.sv */
`timescale 1ns/1ns

`define CHK(nm, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); \
  end \
end

// Self-checking bench for the bus slave with a behavioural master.
module seep_slave_bench;
  localparam int AW = 11;
  localparam int PROG = 200;
  // Clock, reset and bus wires.
  logic clk, rst, scl, sdaDrv, sdaWire, sdaOut, sdaOe;
  // Control pins, memory side and write stream.
  logic wpPin, wrReady, protSet, wrValid, progStart, progBusy, standby, ack;
  logic [AW-1:0] memRdAddr, wrAddr;
  logic [7:0] memRdData, wrData, rd;
  logic [AW-5:0] protPage;
  logic [(1<<(AW-4))-1:0] pageProt;
  // Words taken from the write stream as {address, data}.
  logic [AW+7:0] wrLog[$];
  int num_errors, checks_done, starts, busyLen;

  // Open drain wire with a pull-up: low if any party pulls.
  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  // Memory image is a fixed pattern of the address.
  assign memRdData = memRdAddr[7:0] ^ 8'h5a;

  seep_slave #(.ADDR_W(AW), .PROG_CYCLES(PROG)) i_dut (
    .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .wpPin(wpPin), .memRdAddr(memRdAddr), .memRdData(memRdData), .wrValid(wrValid),
    .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData), .progStart(progStart),
    .progBusy(progBusy), .protSet(protSet), .protPage(protPage), .pageProt(pageProt),
    .standby(standby)
  );

  seep_master_model i_master (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));

  // 50 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Logs stream words, counts programming starts and busy length.
  always @(posedge clk) begin
    if (wrValid === 1'b1 && wrReady === 1'b1) wrLog.push_back({wrAddr, wrData});
    if (progStart === 1'b1) begin
      starts++;
      busyLen <= (progBusy === 1'b1) ? 1 : 0;
    end else if (progBusy === 1'b1) begin
      busyLen <= busyLen + 1;
    end
  end

  // Waits, bounded, for programming to finish.
  task automatic wait_idle();
    int n = 0;
    repeat (8) @(posedge clk);
    while (progBusy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    `CHK("progBusy", 1'b0, progBusy)
  endtask

  // Single byte write at {hi, a}.
  task automatic do_write(input logic [2:0] hi, input logic [7:0] a, input logic [7:0] d);
    i_master.start_cond();
    i_master.byte_w({4'ha, hi, 1'b0}, ack);
    i_master.byte_w(a, ack);
    i_master.byte_w(d, ack);
    `CHK("data ack", 1'b1, ack)
    i_master.stop_cond();
    wait_idle();
  endtask

  task automatic end_test(input string s);
    $display("test %s done, errors %0d", s, num_errors);
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #(40000 * 20);
    $display("ERROR watchdog expected done seen hang");
    num_errors++;
    close_out();
  end

  // Test sequence.
  initial begin
    rst = 1'b1;
    wpPin = 1'b0;
    wrReady = 1'b1;
    protSet = 1'b0;
    protPage = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("standby", 1'b1, standby)
    `CHK("sdaOut", 1'b0, sdaOut)
    `CHK("pageProt any", 1'b0, |pageProt)
    end_test("reset");
    // A foreign type code is ignored.
    i_master.start_cond();
    i_master.byte_w(8'h50, ack);
    `CHK("foreign ack", 1'b0, ack)
    i_master.stop_cond();
    end_test("type code");
    // Stalled sink: two words fill the buffer, the third is refused.
    wrReady <= 1'b0;
    i_master.start_cond();
    i_master.byte_w(8'haa, ack);
    `CHK("cmd ack", 1'b1, ack)
    i_master.byte_w(8'h3e, ack);
    `CHK("addr ack", 1'b1, ack)
    i_master.byte_w(8'h11, ack);
    i_master.byte_w(8'h22, ack);
    `CHK("second ack", 1'b1, ack)
    i_master.byte_w(8'h33, ack);
    `CHK("full ack", 1'b0, ack)
    i_master.stop_cond();
    `CHK("log empty", 0, wrLog.size())
    `CHK("progBusy", 1'b1, progBusy)
    i_master.start_cond();
    i_master.byte_w(8'ha1, ack);
    `CHK("busy ack", 1'b0, ack)
    i_master.stop_cond();
    wrReady <= 1'b1;
    wait_idle();
    `CHK("log size", 2, wrLog.size())
    `CHK("word 0", {11'h53e, 8'h11}, wrLog[0])
    `CHK("word 1", {11'h53f, 8'h22}, wrLog[1])
    `CHK("starts", 1, starts)
    `CHK("busy cycles", PROG, busyLen)
    repeat (8) @(posedge clk);
    `CHK("standby", 1'b1, standby)
    end_test("buffer");
    // Page write wraps inside the sixteen-byte page.
    i_master.start_cond();
    i_master.byte_w(8'ha0, ack);
    i_master.byte_w(8'h0f, ack);
    i_master.byte_w(8'h44, ack);
    i_master.byte_w(8'h55, ack);
    i_master.stop_cond();
    wait_idle();
    `CHK("word 2", {11'h00f, 8'h44}, wrLog[2])
    `CHK("word 3", {11'h000, 8'h55}, wrLog[3])
    end_test("page wrap");
    // Pin protection, then page protection, each drops the data.
    wpPin <= 1'b1;
    do_write(3'h0, 8'h20, 8'h66);
    `CHK("log wp", 4, wrLog.size())
    wpPin <= 1'b0;
    protPage <= 7'h02;
    protSet <= 1'b1;
    @(posedge clk);
    protSet <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("pageProt 2", 1'b1, pageProt[2])
    do_write(3'h0, 8'h25, 8'h77);
    `CHK("log prot", 4, wrLog.size())
    end_test("protect");
    // Random read, sequential byte, then a current address read.
    starts = 0;
    i_master.start_cond();
    i_master.byte_w(8'ha2, ack);
    i_master.byte_w(8'h7e, ack);
    i_master.start_cond();
    i_master.byte_w(8'hab, ack);
    `CHK("read cmd ack", 1'b1, ack)
    i_master.byte_r(1'b1, rd);
    `CHK("read 0", 8'h7e ^ 8'h5a, rd)
    i_master.byte_r(1'b0, rd);
    `CHK("read 1", 8'h7f ^ 8'h5a, rd)
    i_master.stop_cond();
    repeat (8) @(posedge clk);
    `CHK("read starts", 0, starts)
    `CHK("standby", 1'b1, standby)
    i_master.start_cond();
    i_master.byte_w(8'ha1, ack);
    i_master.byte_r(1'b0, rd);
    `CHK("read 2", 8'h80 ^ 8'h5a, rd)
    i_master.stop_cond();
    end_test("read");
    close_out();
  end
endmodule

/* File: verilog/seep_buf.sv */
`timescale 1ns/1ns

// Small FIFO of flip-flops with valid and ready on both sides.
module seep_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // Depth below two would stall the source on every word.
  if (DEPTH < 2) begin : g_chk
    $error("seep_buf needs DEPTH of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage entries.
  logic [PW-1:0] wrPtr;  // Next entry to fill.
  logic [PW-1:0] rdPtr;  // Oldest entry.
  logic [CW-1:0] count;  // Entries held.
  logic [PW-1:0] next_wrPtr;
  logic [PW-1:0] next_rdPtr;
  logic [CW-1:0] next_count;
  logic doPush;
  logic doPop;

  // Pointer step with wrap at the depth.
  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Full and empty come straight from the count, so they never lie.
  assign inReady = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  // Next pointer and count values.
  always_comb begin
    next_wrPtr = doPush ? step(wrPtr) : wrPtr;
    next_rdPtr = doPop ? step(rdPtr) : rdPtr;
    next_count = count;
    if (doPush && !doPop) begin
      next_count = CW'(count + 1'b1);
    end else if (doPop && !doPush) begin
      next_count = CW'(count - 1'b1);
    end
  end

  // Register pointers, count and the written entry.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
      if (doPush) begin
        mem[wrPtr] <= inData;
      end
    end
  end

  // A stalled sink must see the same word until it takes it.
  a_buf_hold: assert property (@(posedge clk) disable iff (rst)
    outValid && !outReady |=> outValid && $stable(outData)) else $error("stalled word changed or vanished");

endmodule

/* File: verilog/seep_map.svh */
`ifndef SEEP_MAP_SVH
`define SEEP_MAP_SVH

// System clock rate in kHz and the programming time limit in ms.
`define SEEP_CLK_KHZ 50000
`define SEEP_PROG_MS 8
// Longest programming time in clock cycles, milliseconds times kHz.
`define SEEP_PROG_CYC (`SEEP_PROG_MS * `SEEP_CLK_KHZ)

// Memory geometry: default address width and page size.
`define SEEP_ADDR_W 11
`define SEEP_PAGE_BITS 4

// Command byte layout: type code field, direction bit, high address field.
`define SEEP_TYPE_CODE 4'ha
`define SEEP_TYPE_MSB 7
`define SEEP_TYPE_LSB 4
`define SEEP_DIR_BIT 0
`define SEEP_HI_LSB 1

// Bit count value that marks the last bit of a byte.
`define SEEP_LAST_BIT 3'h7

`endif

/* File: verilog/seep_pkg.sv */
package seep_pkg;

  // Byte framing states of the bus slave, one-hot.
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_RX   = 7'h02,
    ST_ACKW = 7'h04,
    ST_ACK  = 7'h08,
    ST_TX   = 7'h10,
    ST_MACK = 7'h20,
    ST_SKIP = 7'h40
  } seep_state_t;

  // Which byte of the transaction is expected next, one-hot.
  typedef enum logic [2:0] {
    PH_CMD  = 3'h1,
    PH_ADDR = 3'h2,
    PH_DATA = 3'h4
  } seep_phase_t;

endpackage

/* File: verilog/seep_slave.sv */
`timescale 1ns/1ns
`include "seep_map.svh"

// Contract
// [RULE1] Sample on SCL rise, change on fall.
// [RULE2] SDA is open drain: pull low or release.
// [RULE3] Write protect pin high blocks all writes.
// [RULE4] One protection bit per page blocks writes.
// [RULE5] Pages of sixteen bytes, programmed together.
// [RULE6] Master keeps SCL rate within limit.
// [RULE7] Standby after stop or finished programming.
// [RULE8] SDA fall with SCL high starts transaction.
// [RULE9] Stop ends transaction, starts programming if data.
// [RULE10] Stop after read goes straight to standby.
// [RULE11] Receiver pulls SDA low in ninth clock.
// [RULE12] Transmitter releases SDA after eighth bit.
// [RULE13] Acknowledge every byte once addressed; the code nacks a data byte when its two-entry buffer is full.
// [RULE14] Master acks wanted bytes, nacks last.
// [RULE15] SDA changes only while SCL low.
// [RULE16] Nine clocks per byte, MSB first.
// [RULE17] Command byte bit zero selects direction.
// [RULE18] Write command carries upper address bits.
// [RULE19] Byte after write command is address.
// [RULE20] Read data continues while master acknowledges.
// [RULE21] Slave only, never drives SCL.
// [RULE22] Master supplies every SCL pulse.
// [RULE23] Address counter advances on writes and reads.
// [RULE24] No command acknowledge while programming.
// [RULE25] Programming finishes within eight milliseconds.
// [RULE26] Respond only to matching device type code.
module seep_slave #(
  parameter int ADDR_W = `SEEP_ADDR_W,
  parameter int PROG_CYCLES = `SEEP_PROG_CYC
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Two-wire bus pins; SCL is input only.
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Write protect pin.
  input wire logic wpPin,
  // Memory read port, combinational data for the given address.
  output logic [ADDR_W-1:0] memRdAddr,
  input wire logic [7:0] memRdData,
  // Write data stream toward the page buffer.
  output logic wrValid,
  input wire logic wrReady,
  output logic [ADDR_W-1:0] wrAddr,
  output logic [7:0] wrData,
  // Programming cycle status.
  output logic progStart,
  output logic progBusy,
  // Page protection bit setting and state.
  input wire logic protSet,
  input wire logic [ADDR_W-`SEEP_PAGE_BITS-1:0] protPage,
  output logic [(1<<(ADDR_W-`SEEP_PAGE_BITS))-1:0] pageProt,
  // Idle bus and no programming.
  output logic standby
);

  localparam int HI_W = ADDR_W - 8;
  localparam int PG_W = ADDR_W - `SEEP_PAGE_BITS;
  localparam int PAGES = 1 << PG_W;
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // Only the two documented array sizes are served.
  if (ADDR_W < 10 || ADDR_W > 11 || PROG_CYCLES < 1) begin : g_chk
    $error("seep_slave needs ADDR_W of 10 or 11 and PROG_CYCLES above 0");
  end

  // Synchronisers for the pins; the second stage is read, and a third stage on SCL and SDA gives their edges.
  logic sclM, sclS, sclD;
  logic sdaM, sdaS, sdaD;
  logic wpM, wpS;

  // Framing state.
  seep_pkg::seep_state_t state, next_state;
  seep_pkg::seep_phase_t phase, next_phase;
  logic [2:0] bitCnt, next_bitCnt;  // Bits done in this byte.
  logic [7:0] shiftReg, next_shiftReg;  // Received bits.
  logic [7:0] txReg, next_txReg;  // Byte being sent.
  logic sdaLow, next_sdaLow;  // Pulling SDA low.
  logic isRead, next_isRead;  // Read command seen.
  logic doAck, next_doAck;  // Acknowledge decision for this byte.
  logic mAcked, next_mAcked;  // Master acknowledged the sent byte.
  logic dataTaken, next_dataTaken;  // Write data accepted since the last stop.
  logic [HI_W-1:0] addrHi, next_addrHi;  // Upper address from command.
  logic [ADDR_W-1:0] addr, next_addr;  // Internal address counter.
  logic progGo, next_progStart;
  logic [TW-1:0] progCnt, next_progCnt;
  logic [PAGES-1:0] next_pageProt;
  logic next_standby;

  // Decoded bus events and helpers.
  logic sclRise, sclFall, startDet, stopDet;
  logic [7:0] rxByte;
  logic loadTx;
  logic pushReq, bufReady, writable;

  // Page address held, low four bits wrap inside the page.
  function automatic logic [ADDR_W-1:0] pageIncr(input logic [ADDR_W-1:0] a);
    pageIncr = {a[ADDR_W-1:`SEEP_PAGE_BITS], 4'(a[`SEEP_PAGE_BITS-1:0] + 1'b1)};
  endfunction

  // Pin synchronisers; SCL is sampled like any other pin.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclM <= 1'b1;
      sclS <= 1'b1;
      sclD <= 1'b1;
      sdaM <= 1'b1;
      sdaS <= 1'b1;
      sdaD <= 1'b1;
      wpM <= 1'b1;
      wpS <= 1'b1;
    end else begin
      sclM <= scl;
      sclS <= sclM;
      sclD <= sclS;
      sdaM <= sdaIn;
      sdaS <= sdaM;
      sdaD <= sdaS;
      wpM <= wpPin;
      wpS <= wpM;
    end
  end

  // Edges and conditions; a data change with SCL high is start or stop.
  assign sclRise = sclS && !sclD;  // [RULE1]
  assign sclFall = !sclS && sclD;  // [RULE1]
  assign startDet = sclS && sclD && sdaD && !sdaS;  // [RULE8] [RULE15]
  assign stopDet = sclS && sclD && !sdaD && sdaS;  // [RULE9] [RULE15]
  assign rxByte = {shiftReg[6:0], sdaS};  // [RULE16]

  // The page write target must be unprotected by pin and page bit.
  assign writable = !wpS && !pageProt[addr[ADDR_W-1:`SEEP_PAGE_BITS]];  // [RULE3] [RULE4]

  // The line is only ever pulled low; the pad pull-up makes the high.
  assign sdaOut = 1'b0;  // [RULE2]
  assign sdaOe = sdaLow;  // [RULE2]
  assign memRdAddr = addr;
  assign progBusy = (progCnt != '0);

  // Next framing values. Start and stop override any byte in flight.
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_txReg = txReg;
    next_sdaLow = sdaLow;
    next_isRead = isRead;
    next_doAck = doAck;
    next_mAcked = mAcked;
    next_dataTaken = dataTaken;
    next_addrHi = addrHi;
    next_addr = addr;
    pushReq = 1'b0;
    progGo = 1'b0;
    loadTx = 1'b0;
    case (state)
      // Receive a byte, MSB first, on SCL rises.
      seep_pkg::ST_RX: begin
        if (sclRise) begin
          next_shiftReg = rxByte;  // [RULE1] [RULE16]
          next_bitCnt = 3'(bitCnt + 1'b1);
          if (bitCnt == `SEEP_LAST_BIT) begin
            next_state = seep_pkg::ST_ACKW;
            next_doAck = 1'b0;
            if (phase == seep_pkg::PH_CMD) begin
              // Foreign type code or busy programming gets no answer.
              if (rxByte[`SEEP_TYPE_MSB:`SEEP_TYPE_LSB] == `SEEP_TYPE_CODE && !progBusy) begin  // [RULE26] [RULE24]
                next_doAck = 1'b1;  // [RULE13]
                next_isRead = rxByte[`SEEP_DIR_BIT];  // [RULE17]
                if (!rxByte[`SEEP_DIR_BIT]) begin
                  next_addrHi = rxByte[`SEEP_HI_LSB +: HI_W];  // [RULE18]
                end
              end
            end else if (phase == seep_pkg::PH_ADDR) begin
              next_doAck = 1'b1;  // [RULE13]
              next_addr = {addrHi, rxByte};  // [RULE19]
            end else begin
              // A full buffer refuses the byte rather than lose it.
              next_doAck = bufReady;  // [RULE13]
              if (bufReady) begin
                next_addr = pageIncr(addr);  // [RULE23] [RULE5]
                if (writable) begin
                  pushReq = 1'b1;  // [RULE5]
                  next_dataTaken = 1'b1;
                end
              end
            end
          end
        end
      end
      // Wait for the fall that opens the acknowledge clock.
      seep_pkg::ST_ACKW: begin
        if (sclFall) begin
          if (doAck) begin
            next_sdaLow = 1'b1;  // [RULE11]
            next_state = seep_pkg::ST_ACK;
          end else begin
            next_state = seep_pkg::ST_SKIP;
          end
        end
      end
      // Hold the acknowledge until the ninth clock ends.
      seep_pkg::ST_ACK: begin
        if (sclFall) begin
          next_bitCnt = 3'h0;
          next_phase = (phase == seep_pkg::PH_CMD && !isRead) ? seep_pkg::PH_ADDR : seep_pkg::PH_DATA;
          if (isRead) begin
            loadTx = 1'b1;  // [RULE20]
          end else begin
            next_sdaLow = 1'b0;  // [RULE1]
            next_state = seep_pkg::ST_RX;
          end
        end
      end
      // Send a byte, changing the line on SCL falls.
      seep_pkg::ST_TX: begin
        if (sclFall) begin
          next_bitCnt = 3'(bitCnt + 1'b1);
          if (bitCnt == `SEEP_LAST_BIT) begin
            next_sdaLow = 1'b0;  // [RULE12]
            next_mAcked = 1'b0;
            next_state = seep_pkg::ST_MACK;
          end else begin
            next_txReg = {txReg[6:0], 1'b0};  // [RULE16]
            next_sdaLow = !txReg[6];  // [RULE1]
          end
        end
      end
      // Master acknowledge slot: continue only if it pulled low.
      seep_pkg::ST_MACK: begin
        if (sclRise) begin
          next_mAcked = !sdaS;  // [RULE20]
        end
        if (sclFall) begin
          if (mAcked) begin
            next_bitCnt = 3'h0;
            loadTx = 1'b1;  // [RULE20]
          end else begin
            next_state = seep_pkg::ST_SKIP;
          end
        end
      end
      // Idle or ignoring the rest of a transaction.
      seep_pkg::ST_IDLE, seep_pkg::ST_SKIP: begin
        next_sdaLow = 1'b0;
      end
      default: begin
        next_state = seep_pkg::ST_IDLE;
        next_sdaLow = 1'b0;
      end
    endcase
    // Load the next read byte and drive its first bit at this fall.
    if (loadTx) begin
      next_txReg = memRdData;
      next_sdaLow = !memRdData[7];  // [RULE1]
      next_addr = ADDR_W'(addr + 1'b1);  // [RULE23]
      next_state = seep_pkg::ST_TX;
    end
    if (startDet) begin
      next_state = seep_pkg::ST_RX;  // [RULE8]
      next_phase = seep_pkg::PH_CMD;  // [RULE17]
      next_bitCnt = 3'h0;
      next_sdaLow = 1'b0;
      next_isRead = 1'b0;
    end else if (stopDet) begin
      next_state = seep_pkg::ST_IDLE;  // [RULE7] [RULE10]
      next_sdaLow = 1'b0;
      next_dataTaken = 1'b0;
      progGo = dataTaken;  // [RULE9]
    end
  end

  // Programming timer, page protection bits and standby flag.
  always_comb begin
    next_progStart = progGo;
    next_progCnt = progCnt;
    if (progGo) begin
      next_progCnt = TW'(PROG_CYCLES);  // [RULE25]
    end else if (progCnt != '0) begin
      next_progCnt = TW'(progCnt - 1'b1);
    end
    next_pageProt = pageProt;
    if (protSet) begin
      next_pageProt[protPage] = 1'b1;  // [RULE4]
    end
    next_standby = (state == seep_pkg::ST_IDLE) && !progBusy && sclS && sdaS;  // [RULE7]
  end

  // Register all state; the device never has an SCL driver.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= seep_pkg::ST_IDLE;  // [RULE21]
      phase <= seep_pkg::PH_CMD;
      bitCnt <= 3'h0;
      shiftReg <= 8'h00;
      txReg <= 8'h00;
      sdaLow <= 1'b0;
      isRead <= 1'b0;
      doAck <= 1'b0;
      mAcked <= 1'b0;
      dataTaken <= 1'b0;
      addrHi <= '0;
      addr <= '0;
      progStart <= 1'b0;
      progCnt <= '0;
      pageProt <= '0;
      standby <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      txReg <= next_txReg;
      sdaLow <= next_sdaLow;
      isRead <= next_isRead;
      doAck <= next_doAck;
      mAcked <= next_mAcked;
      dataTaken <= next_dataTaken;
      addrHi <= next_addrHi;
      addr <= next_addr;
      progStart <= next_progStart;
      progCnt <= next_progCnt;
      pageProt <= next_pageProt;
      standby <= next_standby;
    end
  end

  // Two-entry buffer lets the page buffer stall without losing a byte.
  seep_buf #(.WIDTH(ADDR_W + 8), .DEPTH(2)) u_buf (
    .clk(clk),
    .rst(rst),
    .inValid(pushReq),
    .inReady(bufReady),
    .inData({addr, rxByte}),
    .outValid(wrValid),
    .outReady(wrReady),
    .outData({wrAddr, wrData})
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sda_change_edge: assert property ($changed(sdaOe) |-> $past(sclFall) || $past(startDet || stopDet))  // [RULE1]
    else $error("SDA drive changed away from an SCL fall");
  a_wp_blocks: assert property (state == seep_pkg::ST_RX && wpS |-> !pushReq)  // [RULE3]
    else $error("write data pushed while write protect high");
  a_page_prot: assert property (state == seep_pkg::ST_RX && pageProt[addr[ADDR_W-1:`SEEP_PAGE_BITS]] |-> !pushReq)  // [RULE4]
    else $error("write data pushed into protected page");
  a_page_wrap: assert property (pushReq |=> addr[ADDR_W-1:4] == $past(addr[ADDR_W-1:4]))  // [RULE5]
    else $error("address left the page during write");
  a_prog_stop: assert property (progStart |-> $past(stopDet) && $past(dataTaken))  // [RULE9]
    else $error("programming started without a stop");
  a_busy_nack: assert property (state == seep_pkg::ST_ACKW && phase == seep_pkg::PH_CMD && progBusy && sclFall
    |=> !sdaOe)  // [RULE24]
    else $error("command acknowledged while programming");
  a_prog_len: assert property ($rose(progBusy) |-> progBusy [*8])  // [RULE25]
    else $error("programming ended too early");
  a_ack_hold: assert property (state == seep_pkg::ST_ACK |-> sdaOe)  // [RULE11]
    else $error("acknowledge slot not driven low");
  a_tx_release: assert property (state == seep_pkg::ST_MACK |-> !sdaOe)  // [RULE12]
    else $error("SDA held during master acknowledge");
  a_stop_idle: assert property (stopDet |=> state == seep_pkg::ST_IDLE && !sdaOe)  // [RULE10]
    else $error("stop did not return to idle");

endmodule
